// File: shared/gpb_defines.svh
// Register map, field positions and reset values of the GPIO port bank.
// Assumes word addressing on the plain register port, one register per address.
//
// Summary of operation
// - Up to 84 general-purpose pins in total
// - Pins grouped into ports of eight
// - Eight selectable drive modes per pin
// - Analog mode disables input and output buffers
// - Reset forces every pin into analog mode
// - Per-pin CMOS or LVTTL threshold select
// - Hold freezes pins at their last state
// - Per-pin slew-rate setting drives output driver
// - Output value and pin state per port
// - Pin interrupts merge into one port request
// - Signal matrix picks each pin's source
`ifndef GPB_DEFINES_SVH
`define GPB_DEFINES_SVH

// Per-pin configuration at index = pin number
`define GPB_PIN_CFG_BASE  8'h00
// Per-port block at base + 4 * port
`define GPB_PORT_BASE     8'h80
`define GPB_PORT_OUT      2'h0
`define GPB_PORT_STATE    2'h1
`define GPB_PORT_INTR     2'h2
`define GPB_PORT_MASK     2'h3
`define GPB_CTRL          8'hf0

// Pin configuration fields
`define GPB_CFG_MODE_LSB  0
`define GPB_CFG_LVTTL_BIT 3
`define GPB_CFG_SLOW_BIT  4
`define GPB_CFG_EDGE_LSB  5
`define GPB_CFG_SEL_LSB   7
`define GPB_CFG_W         9
`define GPB_CTRL_HOLD_BIT 0

// Reset values
`define GPB_CFG_RST       9'h000
`define GPB_OUT_RST       8'h00
`define GPB_MASK_RST      8'h00
`define GPB_CTRL_RST      1'h0

`endif

// File: shared/gpb_pkg.sv
// Types shared by the GPIO port bank.
// Assumes field order matches the positions in gpb_defines.svh.
package gpb_pkg;

   typedef enum logic [2:0] {
      GPB_ANALOG  = 3'h0,
      GPB_INPUT   = 3'h1,
      GPB_WPU_SPD = 3'h2,
      GPB_SPU_WPD = 3'h3,
      GPB_OD_LOW  = 3'h4,
      GPB_OD_HIGH = 3'h5,
      GPB_STRONG  = 3'h6,
      GPB_WEAK    = 3'h7
   } gpb_drive_t;

   typedef enum logic [1:0] {
      GPB_EDGE_NONE = 2'h0,
      GPB_EDGE_RISE = 2'h1,
      GPB_EDGE_FALL = 2'h2,
      GPB_EDGE_BOTH = 2'h3
   } gpb_edge_t;

   typedef struct packed {
      logic [1:0] sel;
      gpb_edge_t  edge_sel;
      logic       slow;
      logic       lvttl;
      gpb_drive_t mode;
   } gpb_pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic wpu;
      logic wpd;
      logic ie;
   } gpb_pad_t;

endpackage : gpb_pkg

// File: core/gpb_port_bank.sv
// GPIO port bank: drive modes, hold, signal matrix, pin interrupts, registers.
// Assumes pin_in is asynchronous and peripheral signals are on core_clk.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gpb_defines.svh"

module gpb_port_bank #(
   parameter int NUM_PINS   = 84,
   parameter int NUM_PORTS  = 11,
   parameter int PORT_W     = 8,
   parameter int NUM_PERIPH = 3
) (
   input  wire logic                           core_clk,
   input  wire logic                           rst_n,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [31:0]                    reg_rdata,
   output logic                                irq,
   output logic      [NUM_PORTS-1:0]           port_irq,
   input  wire logic [NUM_PINS-1:0]            pin_in,
   output logic      [NUM_PINS-1:0]            pin_out,
   output logic      [NUM_PINS-1:0]            pin_oe,
   output logic      [NUM_PINS-1:0]            pin_wpu,
   output logic      [NUM_PINS-1:0]            pin_wpd,
   output logic      [NUM_PINS-1:0]            pin_ie,
   output logic      [NUM_PINS-1:0]            pin_lvttl,
   output logic      [NUM_PINS-1:0]            pin_slow,
   input  wire logic [NUM_PINS*NUM_PERIPH-1:0] periph_out,
   input  wire logic [NUM_PINS*NUM_PERIPH-1:0] periph_oe,
   output logic      [NUM_PINS-1:0]            periph_in
);

   localparam int BANK_W = NUM_PORTS * PORT_W;

   // Refuse parameter sets the logic cannot serve
   if (NUM_PINS > 84 || NUM_PINS < 1) begin : g_bad_pins
      $error("pin count out of range");
   end
   if (PORT_W > 8 || PORT_W < 1) begin : g_bad_width
      $error("port width out of range");
   end
   if (NUM_PORTS * PORT_W < NUM_PINS || (NUM_PORTS - 1) * PORT_W >= NUM_PINS) begin : g_bad_ports
      $error("port count does not fit pin count");
   end
   if (NUM_PORTS > 28) begin : g_bad_map
      $error("port count exceeds map");
   end
   if (NUM_PERIPH > 3 || NUM_PERIPH < 1) begin : g_bad_periph
      $error("peripheral count out of range");
   end

   logic rst_meta;
   logic rst_s;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_s    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_s    <= rst_meta;
      end
   end

   // Register decode
   logic       cfg_hit;
   logic       port_hit;
   logic [4:0] port_idx;
   logic [1:0] port_sub;
   logic [BANK_W-1:0] out_val;
   logic [BANK_W-1:0] int_mask;
   logic [BANK_W-1:0] int_stat;
   logic [BANK_W-1:0] pin_state;
   logic              hold;
   gpb_pkg::gpb_pin_cfg_t cfg [NUM_PINS];

   assign cfg_hit  = !reg_addr[7] && (int'(reg_addr) < NUM_PINS);
   assign port_idx = reg_addr[6:2];
   assign port_sub = reg_addr[1:0];
   assign port_hit = reg_addr[7] && (reg_addr < `GPB_CTRL) && (int'(port_idx) < NUM_PORTS);

   always_ff @(posedge core_clk or negedge rst_s) begin
      if (!rst_s) begin
         hold <= `GPB_CTRL_RST;
      end else if (reg_wr && reg_addr == `GPB_CTRL) begin
         hold <= reg_wdata[`GPB_CTRL_HOLD_BIT];
      end
   end

   // Read data, valid in the cycle after the strobe only
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd) begin
         if (cfg_hit) begin
            next_rdata[`GPB_CFG_W-1:0] = cfg[reg_addr[6:0]];
         end else if (port_hit) begin
            unique case (port_sub)
               `GPB_PORT_OUT:   next_rdata[PORT_W-1:0] = out_val[port_idx*PORT_W +: PORT_W];
               `GPB_PORT_STATE: next_rdata[PORT_W-1:0] = pin_state[port_idx*PORT_W +: PORT_W];
               `GPB_PORT_INTR:  next_rdata[PORT_W-1:0] = int_stat[port_idx*PORT_W +: PORT_W];
               `GPB_PORT_MASK:  next_rdata[PORT_W-1:0] = int_mask[port_idx*PORT_W +: PORT_W];
            endcase
         end else if (reg_addr == `GPB_CTRL) begin
            next_rdata[`GPB_CTRL_HOLD_BIT] = hold;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_s) begin
      if (!rst_s) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Per-port registers and merged requests
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      // Bits past the last pin are not stored and read as zero
      localparam int LIVE_N = (NUM_PINS - p * PORT_W < PORT_W) ? NUM_PINS - p * PORT_W : PORT_W;
      localparam logic [PORT_W-1:0] LIVE = PORT_W'((1 << LIVE_N) - 1);

      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            out_val[p*PORT_W +: PORT_W] <= `GPB_OUT_RST;
            int_mask[p*PORT_W +: PORT_W] <= `GPB_MASK_RST;
         end else if (reg_wr && port_hit && int'(port_idx) == p) begin
            if (port_sub == `GPB_PORT_OUT)
               out_val[p*PORT_W +: PORT_W] <= reg_wdata[PORT_W-1:0] & LIVE;
            if (port_sub == `GPB_PORT_MASK)
               int_mask[p*PORT_W +: PORT_W] <= reg_wdata[PORT_W-1:0] & LIVE;
         end
      end

      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            port_irq[p] <= 1'b0;
         end else begin
            port_irq[p] <= |(int_stat[p*PORT_W +: PORT_W] & int_mask[p*PORT_W +: PORT_W]);
         end
      end

      port_irq_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         |(int_stat[p*PORT_W +: PORT_W] & int_mask[p*PORT_W +: PORT_W]) |=> port_irq[p])
         else $error("port request missing");

      out_write_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         (reg_wr && port_hit && int'(port_idx) == p && port_sub == `GPB_PORT_OUT)
         |=> out_val[p*PORT_W +: PORT_W] == ($past(reg_wdata[PORT_W-1:0]) & LIVE))
         else $error("output value not stored");
   end

   always_ff @(posedge core_clk or negedge rst_s) begin
      if (!rst_s) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat & int_mask);
      end
   end

   // Unused tail of the last port stays zero
   if (BANK_W > NUM_PINS) begin : g_pad
      assign pin_state[BANK_W-1:NUM_PINS] = '0;
      assign int_stat[BANK_W-1:NUM_PINS]  = '0;
   end

   // Input synchroniser
   logic [NUM_PINS-1:0] in_meta;
   logic [NUM_PINS-1:0] in_sync;

   always_ff @(posedge core_clk or negedge rst_s) begin
      if (!rst_s) begin
         in_meta <= '0;
         in_sync <= '0;
      end else begin
         in_meta <= pin_in;
         in_sync <= in_meta;
      end
   end

   // Per-pin configuration, drive, matrix and interrupt
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      localparam int PORT = i / PORT_W;
      localparam int BIT  = i % PORT_W;

      logic            sample;
      logic            prev;
      logic            edge_hit;
      logic            clr;
      logic            src_v;
      logic            src_en;
      gpb_pkg::gpb_pad_t next_pad;

      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            cfg[i] <= `GPB_CFG_RST;
         end else if (reg_wr && cfg_hit && int'(reg_addr) == i) begin
            cfg[i] <= reg_wdata[`GPB_CFG_W-1:0];
         end
      end

      // Input buffer off reads as zero
      assign sample = in_sync[i] & pin_ie[i];

      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            prev <= 1'b0;
         end else begin
            prev <= sample;
         end
      end

      assign pin_state[i] = prev;

      always_comb begin
         unique case (cfg[i].edge_sel)
            gpb_pkg::GPB_EDGE_NONE: edge_hit = 1'b0;
            gpb_pkg::GPB_EDGE_RISE: edge_hit = sample & ~prev;
            gpb_pkg::GPB_EDGE_FALL: edge_hit = ~sample & prev;
            gpb_pkg::GPB_EDGE_BOTH: edge_hit = sample ^ prev;
         endcase
      end

      assign clr = reg_wr && port_hit && int'(port_idx) == PORT
                   && port_sub == `GPB_PORT_INTR && reg_wdata[BIT];

      // Set wins over a clear in the same cycle
      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            int_stat[i] <= 1'b0;
         end else begin
            int_stat[i] <= edge_hit | (int_stat[i] & ~clr);
         end
      end

      // Source select: port register or a peripheral
      always_comb begin
         if (cfg[i].sel == 2'h0 || int'(cfg[i].sel) > NUM_PERIPH) begin
            src_v  = out_val[i];
            src_en = 1'b1;
         end else begin
            src_v  = periph_out[i*NUM_PERIPH + int'(cfg[i].sel) - 1];
            src_en = periph_oe[i*NUM_PERIPH + int'(cfg[i].sel) - 1];
         end
      end

      always_comb begin
         next_pad     = '0;
         next_pad.out = src_v;
         next_pad.ie  = 1'b1;
         unique case (cfg[i].mode)
            gpb_pkg::GPB_ANALOG:  next_pad.ie = 1'b0;
            gpb_pkg::GPB_INPUT:   next_pad.oe = 1'b0;
            gpb_pkg::GPB_WPU_SPD: begin
               next_pad.oe  = src_en & ~src_v;
               next_pad.wpu = 1'b1;
            end
            gpb_pkg::GPB_SPU_WPD: begin
               next_pad.oe  = src_en & src_v;
               next_pad.wpd = 1'b1;
            end
            gpb_pkg::GPB_OD_LOW:  next_pad.oe = src_en & ~src_v;
            gpb_pkg::GPB_OD_HIGH: next_pad.oe = src_en & src_v;
            gpb_pkg::GPB_STRONG:  next_pad.oe = src_en;
            gpb_pkg::GPB_WEAK: begin
               next_pad.wpu = src_en & src_v;
               next_pad.wpd = src_en & ~src_v;
            end
         endcase
      end

      // Hold freezes every pad control
      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            pin_out[i]   <= 1'b0;
            pin_oe[i]    <= 1'b0;
            pin_wpu[i]   <= 1'b0;
            pin_wpd[i]   <= 1'b0;
            pin_ie[i]    <= 1'b0;
            pin_lvttl[i] <= 1'b0;
            pin_slow[i]  <= 1'b0;
         end else if (!hold) begin
            pin_out[i]   <= next_pad.out;
            pin_oe[i]    <= next_pad.oe;
            pin_wpu[i]   <= next_pad.wpu;
            pin_wpd[i]   <= next_pad.wpd;
            pin_ie[i]    <= next_pad.ie;
            pin_lvttl[i] <= cfg[i].lvttl;
            pin_slow[i]  <= cfg[i].slow;
         end
      end

      always_ff @(posedge core_clk or negedge rst_s) begin
         if (!rst_s) begin
            periph_in[i] <= 1'b0;
         end else begin
            periph_in[i] <= sample;
         end
      end

      analog_off_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         (cfg[i].mode == gpb_pkg::GPB_ANALOG && !hold)
         |=> !pin_oe[i] && !pin_ie[i] && !pin_wpu[i] && !pin_wpd[i])
         else $error("analog pin not isolated");

      reset_analog_a: assert property (@(posedge core_clk)
         $rose(rst_s) |-> !pin_oe[i] && !pin_ie[i] && cfg[i].mode == gpb_pkg::GPB_ANALOG)
         else $error("pin not analog after reset");

      strong_drive_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         (cfg[i].mode == gpb_pkg::GPB_STRONG && cfg[i].sel == 2'h0 && !hold)
         |=> pin_oe[i] && pin_out[i] == $past(out_val[i]))
         else $error("strong mode not driving");

      hold_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         hold[*2] |-> $stable(pin_oe[i]) && $stable(pin_out[i]) && $stable(pin_ie[i]))
         else $error("held pin changed");

      thresh_slew_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         !hold |=> pin_lvttl[i] == $past(cfg[i].lvttl) && pin_slow[i] == $past(cfg[i].slow))
         else $error("threshold or slew not applied");

      periph_route_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         (cfg[i].sel == 2'h1 && cfg[i].mode == gpb_pkg::GPB_STRONG && !hold)
         |=> pin_out[i] == $past(periph_out[i*NUM_PERIPH])
             && pin_oe[i] == $past(periph_oe[i*NUM_PERIPH]))
         else $error("peripheral not routed");

      edge_flag_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         edge_hit |=> int_stat[i] ##1 (int_stat[i] || $past(clr)))
         else $error("edge flag lost");

      state_read_a: assert property (@(posedge core_clk) disable iff (!rst_s)
         (reg_rd && port_hit && int'(port_idx) == PORT && port_sub == `GPB_PORT_STATE)
         |=> reg_rdata[BIT] == $past(pin_state[i]))
         else $error("pin state read wrong");
   end

endmodule : gpb_port_bank
`default_nettype wire

// File: tb/gpb_pad_model.sv
// Board side of the pads: resolves each pin level from bank drivers and board drive.
// Assumes the bench supplies board drive values and enables.
`timescale 1ns/1ns
`default_nettype none
module gpb_pad_model #(
   parameter int N = 84
) (
   input  wire logic         core_clk,
   input  wire logic [N-1:0] pin_out,
   input  wire logic [N-1:0] pin_oe,
   input  wire logic [N-1:0] pin_wpu,
   input  wire logic [N-1:0] pin_wpd,
   input  wire logic [N-1:0] ext_val,
   input  wire logic [N-1:0] ext_en,
   output logic      [N-1:0] pin_in
);
   logic [N-1:0] wander = '0;
   // Undriven pads wander every cycle
   always @(posedge core_clk) wander <= ~wander;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                     pin_wpu[i] ? 1'b1 : pin_wpd[i] ? 1'b0 : wander[i];
      end
   end
endmodule : gpb_pad_model
`default_nettype wire

// File: tb/test_gpio_port_bank.sv
// Self-checking bench for the GPIO port bank.
// Assumes the pad model stands on the pins; the bench plays software and board.
`timescale 1ns/1ns
`default_nettype none
`include "gpb_defines.svh"
module test_gpio_port_bank;
   localparam int NP = 84;
   logic            core_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic [7:0]      reg_addr = 8'h00;
   logic [31:0]     reg_wdata = 32'h0;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   logic [31:0]     reg_rdata, rd;
   logic            irq;
   logic [10:0]     port_irq;
   logic [NP-1:0]   pin_in, pin_out, pin_oe, pin_wpu, pin_wpd, pin_ie, pin_lvttl, pin_slow;
   logic [NP-1:0]   periph_in;
   logic [NP-1:0]   ext_val = '0;
   logic [NP-1:0]   ext_en = '0;
   logic [NP*3-1:0] periph_out = '0;
   logic [NP*3-1:0] periph_oe = '0;
   int              errors = 0;
   int              samples_checked = 0;
   int              cycles = 0;
   integer          seed = 32'hd204;

   always #5 core_clk = ~core_clk;

   gpb_port_bank i_gpb_port_bank (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .port_irq, .pin_in, .pin_out, .pin_oe, .pin_wpu, .pin_wpd, .pin_ie,
      .pin_lvttl, .pin_slow, .periph_out, .periph_oe, .periph_in);
   gpb_pad_model i_gpb_pad_model (.core_clk, .pin_out, .pin_oe, .pin_wpu, .pin_wpd, .ext_val,
      .ext_en, .pin_in);

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : rdr
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   function automatic logic [7:0] pa(input int p, input int o);
      return 8'(`GPB_PORT_BASE + 4 * p + o);
   endfunction : pa
   function automatic logic [31:0] cfg(input int m, input int e, input int s);
      return 32'((s << `GPB_CFG_SEL_LSB) | (e << `GPB_CFG_EDGE_LSB) | m);
   endfunction : cfg
   function automatic logic exp_oe(input int m, input logic v);
      case (m)
         2, 4: return ~v;
         3, 5: return v;
         6: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : exp_oe
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      int          n, p, b, m, e;
      logic [31:0] x;
      ext_en <= '1;
      ext_val <= NP'({$random(seed), $random(seed), $random(seed)});
      wt(2);
      chk("pads in reset", 32'({|pin_oe, |pin_ie, |pin_wpu, |pin_wpd, |pin_out}), 0);
      @(posedge core_clk);
      rst_n <= 1'b1;
      wt(4);
      chk("pads after reset", 32'({|pin_oe, |pin_ie, |pin_wpu, |pin_wpd}), 0);
      for (n = 0; n < 4; n++) begin
         rdr(n == 0 ? 8'd83 : n == 1 ? pa(3, 0) : n == 2 ? pa(3, 3) : `GPB_CTRL);
         chk("reset value", rd, 32'h0);
      end
      wr(8'hc0, $random(seed));
      rdr(8'hc0);
      chk("unmapped", rd, 32'h0);
      wr(pa(10, 0), 32'hffffffff);
      rdr(pa(10, 0));
      chk("short port", rd, 32'h0f);
      // Threshold and slew bits, pin 83 first
      for (m = 0; m < 8; m++) begin
         n = (m == 0) ? 83 : {$random(seed)} % NP;
         x = $random(seed) & 32'h1ff;
         wr(8'(n), x);
         wt(2);
         chk("lvttl", pin_lvttl[n], x[`GPB_CFG_LVTTL_BIT]);
         chk("slow", pin_slow[n], x[`GPB_CFG_SLOW_BIT]);
         rdr(8'(n));
         chk("cfg readback", rd, x);
      end
      n = {$random(seed)} % NP;
      for (m = 0; m < 16; m++) begin
         wr(pa(n / 8, 0), 32'(m % 2) << (n % 8));
         wr(8'(n), cfg(m / 2, 0, 0));
         wt(3);
         chk("oe", pin_oe[n], exp_oe(m / 2, m % 2));
         chk("ie", pin_ie[n], 32'(m / 2 != 0));
         if (exp_oe(m / 2, m % 2)) chk("out", pin_out[n], 32'(m % 2));
         if (m / 2 == 7) chk("weak", {pin_wpu[n], pin_wpd[n]}, m % 2 ? 2 : 1);
      end
      for (n = 0; n < NP; n++) wr(8'(n), cfg(1, 0, 0));
      for (p = 0; p < 11; p++) begin
         wt(5);
         rdr(pa(p, 1));
         x = 0;
         for (b = 0; b < 8; b++) if (p * 8 + b < NP) x[b] = ext_val[p * 8 + b];
         chk("pin state", rd, x);
         chk("periph in", periph_in[p * 8], ext_val[p * 8]);
      end
      n = {$random(seed)} % NP;
      p = n / 8;
      b = n % 8;
      ext_val[n] <= 1'b0;
      wr(pa(p, 3), 32'h1 << b);
      for (e = 0; e < 4; e++) begin
         wr(8'(n), cfg(1, e, 0));
         wt(5);
         wr(pa(p, 2), 32'hff);
         wt(3);
         chk("quiet", irq, 0);
         for (m = 0; m < 2; m++) begin
            ext_val[n] <= ~ext_val[n];
            wt(6);
            chk("port irq", port_irq[p], 32'(e[m]));
            chk("irq", irq, 32'(e[m]));
            rdr(pa(p, 2));
            chk("status", rd, 32'(e[m]) << b);
            wr(pa(p, 2), 32'h1 << b);
            wt(3);
         end
      end
      wr(pa(p, 3), 32'h0);
      ext_val[n] <= 1'b1;
      wt(6);
      chk("masked", irq, 0);
      wr(pa(p, 3), 32'h1 << b);
      wt(3);
      chk("unmasked", port_irq[p], 1);
      wr(pa(p, 2), 32'h1 << b);
      wt(3);
      chk("cleared", irq, 0);
      wr(pa(p, 0), 32'h1 << b);
      wr(8'(n), cfg(6, 0, 0));
      wr(`GPB_CTRL, 32'h1);
      wr(pa(p, 0), 32'h0);
      wt(3);
      chk("held", pin_out[n], 1);
      wr(`GPB_CTRL, 32'h0);
      wt(3);
      chk("released", pin_out[n], 0);
      for (m = 1; m < 4; m++) begin
         periph_out <= (NP * 3)'({8{$random(seed)}});
         periph_oe <= (NP * 3)'({8{$random(seed)}});
         wr(8'(n), cfg(6, 0, m));
         wt(6);
         x[0] = periph_oe[n * 3 + m - 1];
         x[1] = periph_out[n * 3 + m - 1];
         chk("matrix oe", pin_oe[n], x[0]);
         if (x[0]) chk("matrix out", pin_out[n], x[1]);
         chk("matrix in", periph_in[n], x[0] ? x[1] : ext_val[n]);
      end
      tally_and_finish();
   end
endmodule : test_gpio_port_bank
`default_nettype wire
